// ---- inc/dal_consts.svh ----
`ifndef DAL_CONSTS_SVH
`define DAL_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses on the 32-bit register port)
// ****************************************************************
`define DAL_OFS_CTRL 8'h00
`define DAL_OFS_ADDR 8'h04
`define DAL_OFS_CMD 8'h08
`define DAL_OFS_STATUS 8'h0C
`define DAL_OFS_XFER_LO 8'h10
`define DAL_OFS_XFER_HI 8'h14

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define DAL_CMD_REF_BIT 0
`define DAL_CMD_READ_BIT 1
`define DAL_CMD_WRITE_BIT 2
`define DAL_CTRL_RST 3'h1
`define DAL_ADDR_RST 15'h4000
`define DAL_GROUP_RST 2'h0
`define DAL_INDEX_ALL_ONES 12'hFFF

// ****************************************************************
// Timing: figures in ns, counts derived from the clock period
// ****************************************************************
`define DAL_CLK_PERIOD_NS 100
`define DAL_PH1_AFTER_PH0_NS 2000
`define DAL_PH3_AFTER_PH1_NS 4000
`define DAL_GROUP_SETTLE_NS 32000
`define DAL_PH1_CYC (`DAL_PH1_AFTER_PH0_NS / `DAL_CLK_PERIOD_NS)
`define DAL_PH3_CYC (`DAL_PH3_AFTER_PH1_NS / `DAL_CLK_PERIOD_NS)
`define DAL_SETTLE_CYC ((`DAL_GROUP_SETTLE_NS + `DAL_CLK_PERIOD_NS - 1) / `DAL_CLK_PERIOD_NS)

`endif

// ---- inc/dal_pkg.sv ----
`default_nettype none
package dal_pkg;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        DAL_IDLE = 5'b00001,
        DAL_SETTLE = 5'b00010,
        DAL_READ = 5'b00100,
        DAL_WARM = 5'b01000,
        DAL_WRITE = 5'b10000
    } dal_state_t;

    // Drum-side outputs travelling together
    typedef struct packed {
        logic [3:0] group_en;
        logic coincidence;
        logic read_pulse;
        logic write_pulse;
        logic phase3;
    } dal_drum_out_t;

    // Command word fields
    typedef struct packed {
        logic write_req;
        logic read_req;
        logic reference_req;
    } dal_cmd_t;

endpackage

`default_nettype wire

// ---- rtl/dal_locator.sv ----
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "dal_consts.svh"

module dal_locator #(
    parameter int PH1_CYC = `DAL_PH1_CYC,
    parameter int PH3_CYC = `DAL_PH3_CYC,
    parameter int SETTLE_CYC = `DAL_SETTLE_CYC,
    parameter int HEADS = 36
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic drum_timing_i,
    input wire logic mark_notch_i,
    input wire logic [HEADS-1:0] head_data_i,
    output var dal_pkg::dal_drum_out_t drum_o
);
    import dal_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    generate
        if (PH1_CYC < 1 || PH3_CYC < 1 || PH1_CYC + PH3_CYC > 255) begin : g_bad_phase
            $error("phase spacing out of range");
        end
        if (SETTLE_CYC < 1 || SETTLE_CYC > 4095) begin : g_bad_settle
            $error("settle count out of range");
        end
        if (HEADS != 36) begin : g_bad_heads
            $error("transfer register is laid out for 36 heads");
        end
    endgenerate

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [1:0] timing_sync_q;
    logic [1:0] notch_sync_q;
    logic [HEADS-1:0] head_meta_q;
    logic [HEADS-1:0] head_sync_q;
    logic timing_last_q;
    logic [7:0] phase_cnt_q;
    logic [7:0] phase_cnt_d;
    logic [2:0] ctrl_q;
    logic [14:0] addr_q;
    logic [11:0] index_q;
    logic [11:0] index_d;
    logic preload_q;
    logic lockout_q;
    logic advance_q;
    logic [1:0] group_q;
    logic [11:0] settle_q;
    logic [35:0] xfer_q;
    logic [31:0] rdata_q;
    dal_state_t state_q;
    dal_state_t state_d;
    dal_drum_out_t drum_q;

    // ****************************************************************
    // Drum input synchronisers
    // ****************************************************************
    // Two stages on every pin input; only the second stage is read by logic
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timing_sync_q <= 2'h0;
            notch_sync_q <= 2'h0;
            timing_last_q <= 1'b0;
        end else begin
            timing_sync_q <= {timing_sync_q[0], drum_timing_i};
            notch_sync_q <= {notch_sync_q[0], mark_notch_i};
            timing_last_q <= timing_sync_q[1];
        end
    end

    // Head sense lines, one synchroniser per head
    genvar gi;
    generate
        for (gi = 0; gi < HEADS; gi++) begin : g_head_sync
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    head_meta_q[gi] <= 1'b0;
                    head_sync_q[gi] <= 1'b0;
                end else begin
                    head_meta_q[gi] <= head_data_i[gi];
                    head_sync_q[gi] <= head_meta_q[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Phase pulse distributor
    // ****************************************************************
    // Each timing pulse edge is phase0; phase1 and phase3 follow at fixed spacing
    wire timing_edge = timing_sync_q[1] & ~timing_last_q;
    wire phase0 = timing_edge;
    wire phase1 = ~timing_edge && (phase_cnt_q == 8'(PH1_CYC));
    wire phase3 = ~timing_edge && (phase_cnt_q == 8'(PH1_CYC + PH3_CYC));
    wire mark_pulse = timing_edge & notch_sync_q[1];

    // Counter restarts on every timing edge and parks after phase3
    always_comb begin
        phase_cnt_d = phase_cnt_q;
        if (timing_edge) begin
            phase_cnt_d = 8'h01;
        end else if (phase_cnt_q != 8'h00) begin
            phase_cnt_d = phase3 ? 8'h00 : phase_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_cnt_q <= 8'h00;
        end else begin
            phase_cnt_q <= phase_cnt_d;
        end
    end

    // ****************************************************************
    // Address interlace
    // ****************************************************************
    // Control code to shift amount; unsupported codes are refused on write
    function automatic logic [3:0] shift_of(input logic [2:0] sel);
        case (sel)
            3'h0: shift_of = 4'h0;
            3'h1: shift_of = 4'h2;
            3'h2: shift_of = 4'h3;
            3'h3: shift_of = 4'h4;
            3'h4: shift_of = 4'h5;
            3'h5: shift_of = 4'h6;
            default: shift_of = 4'h0;
        endcase
    endfunction

    wire [3:0] shift_amt = shift_of(ctrl_q);
    wire [23:0] angle_dbl = {addr_q[11:0], addr_q[11:0]} << shift_amt;
    wire [11:0] angle_remap = angle_dbl[23:12];
    wire [1:0] req_group = addr_q[13:12];

    // ****************************************************************
    // Register port decode
    // ****************************************************************
    wire wr_ctrl = reg_wr_i && (reg_addr_i == `DAL_OFS_CTRL);
    wire wr_addr = reg_wr_i && (reg_addr_i == `DAL_OFS_ADDR);
    wire wr_cmd = reg_wr_i && (reg_addr_i == `DAL_OFS_CMD);
    wire wr_xfer = reg_wr_i && (reg_addr_i == `DAL_OFS_XFER_LO);
    wire ctrl_ok = reg_wdata_i[2:0] <= 3'h5;
    dal_cmd_t cmd;
    assign cmd = reg_wdata_i[2:0];
    wire idle = (state_q == DAL_IDLE);
    // Reference plus exactly one of read or write, only while idle
    wire start_read = wr_cmd && idle && cmd.reference_req && cmd.read_req
                      && !cmd.write_req;
    wire start_write = wr_cmd && idle && cmd.reference_req && cmd.write_req
                       && !cmd.read_req;
    wire group_change = (start_read || start_write) && (req_group != group_q);

    // ****************************************************************
    // Location control
    // ****************************************************************
    wire writing = (state_q == DAL_WRITE);
    wire write_armed = (state_q == DAL_WARM) || writing;
    wire load_ones = phase0 & preload_q;
    wire adv_ph0 = phase0 & ~preload_q & ~writing;
    wire adv_ph1 = phase1 & write_armed;
    wire index_inc = adv_ph0 | adv_ph1;
    wire wrap_carry = index_inc && (index_q == `DAL_INDEX_ALL_ONES);
    // Probes compare the count before it advances
    wire probe_read = adv_ph0 && (state_q == DAL_READ) && !lockout_q;
    wire probe_write = adv_ph1 && !lockout_q;
    wire angle_eq = (index_q == angle_remap);
    wire read_hit = probe_read & angle_eq;
    wire write_hit = probe_write & angle_eq;

    // Index counter next value
    always_comb begin
        index_d = index_q;
        if (load_ones) begin
            index_d = `DAL_INDEX_ALL_ONES;
        end else if (index_inc) begin
            index_d = index_q + 12'h001;
        end
    end

    // Preload, lockout and advance flags; a mark wins over the preload clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            index_q <= 12'h000;
            preload_q <= 1'b0;
            lockout_q <= 1'b1;
            advance_q <= 1'b0;
        end else begin
            index_q <= index_d;
            preload_q <= mark_pulse | (preload_q & ~load_ones);
            lockout_q <= load_ones | (lockout_q ^ wrap_carry);
            advance_q <= adv_ph1 | (advance_q & ~(load_ones | adv_ph0));
        end
    end

    // ****************************************************************
    // Reference sequencer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            DAL_IDLE: begin
                if (start_read) begin
                    state_d = group_change ? DAL_SETTLE : DAL_READ;
                end else if (start_write) begin
                    state_d = DAL_WARM;
                end
            end
            DAL_SETTLE: begin
                if (settle_q == 12'h001) begin
                    state_d = DAL_READ;
                end
            end
            DAL_READ: begin
                if (read_hit) begin
                    state_d = DAL_IDLE;
                end
            end
            DAL_WARM: begin
                if (write_hit) begin
                    state_d = DAL_IDLE;
                end else if (adv_ph1) begin
                    state_d = DAL_WRITE;
                end
            end
            DAL_WRITE: begin
                if (write_hit) begin
                    state_d = DAL_IDLE;
                end
            end
            default: begin
                state_d = DAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= DAL_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Head recovery hold-off after a group switch on read
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            settle_q <= 12'h000;
        end else if (start_read && group_change) begin
            settle_q <= 12'(SETTLE_CYC);
        end else if (settle_q != 12'h000) begin
            settle_q <= settle_q - 12'h001;
        end
    end

    // ****************************************************************
    // Group selection and software registers
    // ****************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            group_q <= `DAL_GROUP_RST;
            ctrl_q <= `DAL_CTRL_RST;
            addr_q <= `DAL_ADDR_RST;
        end else begin
            if (group_change) begin
                group_q <= req_group;
            end
            if (wr_ctrl && ctrl_ok && idle) begin
                ctrl_q <= reg_wdata_i[2:0];
            end
            if (wr_addr && idle) begin
                addr_q <= reg_wdata_i[14:0];
            end
        end
    end

    // Transfer register: ones only on a read hit; a hit wins over the clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            xfer_q <= 36'h0;
        end else if (read_hit) begin
            xfer_q <= xfer_q | head_sync_q;
        end else if (wr_xfer) begin
            xfer_q <= 36'h0;
        end
    end

    // ****************************************************************
    // Drum outputs
    // ****************************************************************
    // One-hot group enable from the selector, pulses on a hit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drum_q <= '0;
        end else begin
            drum_q.group_en <= 4'h1 << group_q;
            drum_q.coincidence <= read_hit | write_hit;
            drum_q.read_pulse <= read_hit;
            drum_q.write_pulse <= write_hit;
            drum_q.phase3 <= phase3;
        end
    end

    assign drum_o = drum_q;

    // ****************************************************************
    // Read data path
    // ****************************************************************
    wire [31:0] status_word = {12'h000, (state_q == DAL_SETTLE), group_q, write_armed,
                               (state_q == DAL_READ), advance_q, preload_q, lockout_q,
                               index_q};
    wire [31:0] rd_mux =
        (reg_addr_i == `DAL_OFS_CTRL) ? {29'h0, ctrl_q} :
        (reg_addr_i == `DAL_OFS_ADDR) ? {17'h0, addr_q} :
        (reg_addr_i == `DAL_OFS_STATUS) ? status_word :
        (reg_addr_i == `DAL_OFS_XFER_LO) ? xfer_q[31:0] :
        (reg_addr_i == `DAL_OFS_XFER_HI) ? {28'h0, xfer_q[35:32]} : 32'h0;

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= reg_rd_i ? rd_mux : 32'h0;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule

`default_nettype wire

// ---- dv/dal_locator_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checker
// ****
module dal_locator_checker #(
    parameter int PH1_CYC = 20,
    parameter int PH3_CYC = 40,
    parameter int SETTLE_CYC = 320,
    parameter int HEADS = 36
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic drum_timing_i,
    input wire logic mark_notch_i,
    input wire logic [HEADS-1:0] head_data_i,
    input wire dal_pkg::dal_drum_out_t drum_o
);
    import dal_pkg::*;
    localparam int P3_LO = PH1_CYC + PH3_CYC + 2;
    localparam int P3_HI = PH1_CYC + PH3_CYC + 6;
    logic tim_q;
    logic [3:0] since_q;
    logic [1:0] grp_q;
    logic cmd_rd;
    // Age of the last timing rise, and the group last written
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tim_q <= 1'b0;
            since_q <= 4'hF;
            grp_q <= 2'h0;
        end else begin
            tim_q <= drum_timing_i;
            if (drum_timing_i && !tim_q) since_q <= 4'h0;
            else if (since_q != 4'hF) since_q <= since_q + 4'h1;
            if (reg_wr_i && reg_addr_i == 8'h04) grp_q <= reg_wdata_i[13:12];
        end
    end
    // Read command written to the command register, whether or not the sequencer is idle
    assign cmd_rd = reg_wr_i && reg_addr_i == 8'h08 && reg_wdata_i[2:0] == 3'h3;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_rise;
        $rose(drum_timing_i);
    endsequence
    sequence s_phase3_due;
        ##[P3_LO:P3_HI] drum_o.phase3;
    endsequence
    a_group_onehot: assert property ($past(reset_n_i) |-> $onehot(drum_o.group_en))
        else $error("group enable not one-hot");
    a_read_is_hit: assert property (drum_o.read_pulse |-> drum_o.coincidence)
        else $error("read pulse without coincidence");
    a_hits_apart: assert property (!(drum_o.read_pulse && drum_o.write_pulse))
        else $error("read and write hit together");
    a_hit_single: assert property (drum_o.coincidence |=> !drum_o.coincidence [*3])
        else $error("coincidence repeated");
    a_phase3_timing: assert property (s_rise |-> s_phase3_due)
        else $error("phase3 pulse missing after timing pulse");
    a_read_phase0: assert property (drum_o.read_pulse |-> since_q inside {[1:5]})
        else $error("read hit away from phase0");
    a_write_phase1: assert property (drum_o.write_pulse |-> since_q inside {[3:7]})
        else $error("write hit away from phase1");
    a_group_follows: assert property (cmd_rd |-> ##[1:3] drum_o.group_en == 4'h1 << grp_q)
        else $error("group enable does not follow address");
    a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read cycle");
endmodule
bind dal_locator dal_locator_checker #(.PH1_CYC(PH1_CYC), .PH3_CYC(PH3_CYC),
    .SETTLE_CYC(SETTLE_CYC), .HEADS(HEADS)) u_checker (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .drum_timing_i(drum_timing_i),
    .mark_notch_i(mark_notch_i), .head_data_i(head_data_i), .drum_o(drum_o));
`default_nettype wire

// ---- dv/dal_drum_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// Rotating drum: timing track, mark notch, head sense lines
// ****
module dal_drum_model #(
    parameter int REV = 4160,
    parameter int START = 4150,
    parameter int HEADS = 36
) (
    output logic drum_timing_o,
    output logic mark_notch_o,
    output logic [HEADS-1:0] head_data_o,
    output logic [12:0] pos_o
);
    // One position every 800 ns, free running, unrelated to the system clock
    initial begin
        drum_timing_o = 1'b0;
        mark_notch_o = 1'b0;
        pos_o = 13'(START);
        head_data_o = '0;
        #37;
        forever begin
            pos_o = (pos_o == 13'(REV - 1)) ? 13'h0000 : pos_o + 13'h0001;
            mark_notch_o = (pos_o == 13'h0000); // Notch only at position 0
            head_data_o = HEADS'({4'h9, 19'h00000, pos_o}); // Cell holds its position
            drum_timing_o = 1'b1;
            #200;
            drum_timing_o = 1'b0;
            #600;
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// Locator testbench
// ****
module tb_top;
    import dal_pkg::*;
    localparam int LIMIT = 45000;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic drum_timing_i;
    logic mark_notch_i;
    logic [35:0] head_data_i;
    logic [12:0] pos;
    dal_drum_out_t drum_o;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [35:0] xf;
    logic [1:0] grp_prev = 2'h0;
    logic [11:0] ang [6] = '{12'h020, 12'hC10, 12'h010, 12'h010, 12'h810, 12'h809};

    dal_locator #(.PH1_CYC(2), .PH3_CYC(4), .SETTLE_CYC(3)) DUT (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .drum_timing_i(drum_timing_i),
        .mark_notch_i(mark_notch_i), .head_data_i(head_data_i), .drum_o(drum_o));
    dal_drum_model u_drum (
        .drum_timing_o(drum_timing_i), .mark_notch_o(mark_notch_i),
        .head_data_o(head_data_i), .pos_o(pos));

    // Clock and hang guard
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdr(input logic [7:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        rd = reg_rdata_o;
        @(posedge clk_i);
    endtask
    // Park late in a drum period, after its phase0 and phase1
    task automatic wait_pos(input int k);
        while (pos !== 13'(k)) @(pos);
        repeat (7) @(posedge clk_i);
    endtask
    task automatic wait_hit(input logic w, input int lim);
        int n;
        n = 0;
        #1;
        while ((w ? drum_o.write_pulse : drum_o.read_pulse) !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check("hit seen", 36'h1, 36'(n < lim));
        check("coincidence", 36'h1, 36'(drum_o.coincidence));
        @(posedge clk_i);
    endtask
    task automatic get_xf();
        rdr(8'h10);
        xf[31:0] = rd;
        rdr(8'h14);
        xf[35:32] = rd[3:0];
    endtask
    function automatic logic [35:0] pat(input int k);
        return {4'h9, 19'h00000, 13'(k)};
    endfunction
    function automatic logic [11:0] rotl(input logic [11:0] a, input int s);
        logic [23:0] t;
        t = {a, a} << s;
        return t[23:12];
    endfunction
    task automatic do_read(input int c, input logic [1:0] g, input logic [11:0] a,
        input logic clr);
        wr(8'h00, 32'(c));
        wr(8'h04, {18'h00001, g, a});
        if (clr) wr(8'h10, 32'h0);
        wr(8'h08, 32'h3);
        rdr(8'h0C);
        check("settle", 36'(g != grp_prev), 36'(rd[19]));
        wait_hit(1'b0, 12000);
        check("group enable", 36'(4'h1 << g), 36'(drum_o.group_en));
        grp_prev = g;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        rdr(8'h0C);
        check("status reset", 36'h1000, 36'(rd));
        rdr(8'h00);
        check("ctrl reset", 36'h1, 36'(rd));
        rdr(8'h04);
        check("addr reset", 36'h4000, 36'(rd));
        rdr(8'h18);
        check("unmapped", 36'h0, 36'(rd));
        wr(8'h00, 32'h6);
        rdr(8'h00);
        check("ctrl refused", 36'h1, 36'(rd));
        wait_pos(0);
        rdr(8'h0C);
        check("preload", 36'h3, 36'(rd[14:12]));
        wait_pos(10);
        rdr(8'h0C);
        check("index after mark", 36'h8, 36'(rd[14:0]));
        for (int c = 0; c < 6; c++) begin
            do_read(c, 2'(c), ang[c], 1'b1);
            get_xf();
            check("read data", pat(rotl(ang[c], c == 0 ? 0 : c + 1) + 3), xf);
        end
        do_read(0, 2'h1, 12'h400, 1'b0);
        get_xf();
        check("ones merge", pat(611) | pat(1027), xf);
        wait_pos(1040);
        rdr(8'h0C);
        check("idle index", 36'h40E, 36'(rd[11:0]));
        wr(8'h08, 32'h1);
        rdr(8'h0C);
        check("lone reference", 36'h0, 36'(rd[16:15]));
        wr(8'h04, 32'h5700);
        wr(8'h08, 32'h5);
        wait_pos(1050);
        rdr(8'h0C);
        check("write double step", 36'h1419, 36'({rd[16], rd[11:0]}));
        wr(8'h00, 32'h2);
        rdr(8'h00);
        check("ctrl while busy", 36'h0, 36'(rd));
        wait_hit(1'b1, 8000);
        wait_pos(1900);
        rdr(8'h0C);
        check("index after write", 36'h76B, 36'({rd[16], rd[11:0]}));
        wait_pos(4100);
        rdr(8'h0C);
        check("lockout after wrap", 36'h1003, 36'(rd[12:0]));
        do_read(0, 2'h1, 12'h00A, 1'b1);
        get_xf();
        check("no dead space probe", pat(13), xf);
        print_verdict();
    end
endmodule
`default_nettype wire
